// file: hw/bcc_core.sv
// Summary of operation
// - Each Hall input passes a 1.6 us deglitch filter before commutation.
// - Direction low commutates forward, high commutates reverse.
// - Direction input at over-range test level forces reset.
// - Width/reset low gives 150 degree drive; high enters reset.
// - Width/reset over-range gives 120 degree drive instead of reset.
// - In reset all six drive outputs are held low.
// - In reset the internal counters keep running.
// - Lead angle is a 4-bit code, 0 to 28 degrees, advancing commutation.
// - Speed pulse: one per revolution if select high, three if low.
// - PWM on-pulses last at least 0.6 us, never shorter.
// - Overcurrent forces low sides off until the next carrier cycle.
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module bcc_core (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite slave
   input  wire logic [3:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [3:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // Hall comparator pins
   input  wire logic        hall_a_plus,
   input  wire logic        hall_a_minus,
   input  wire logic        hall_b_plus,
   input  wire logic        hall_b_minus,
   input  wire logic        hall_c_plus,
   input  wire logic        hall_c_minus,
   // Mode pins
   input  wire logic        direction_select,
   input  wire logic        direction_overrange,
   input  wire logic        width_reset_select,
   input  wire logic        width_overrange,
   input  wire logic        pulse_count_select,
   input  wire logic        overcurrent_sense,
   // Quantized analog levels
   input  wire logic [7:0]  speed_command_level,
   input  wire logic [7:0]  advance_angle_level,
   // Gate drives and speed pulse
   output logic             phase_a_high_drive,
   output logic             phase_a_low_drive,
   output logic             phase_b_high_drive,
   output logic             phase_b_low_drive,
   output logic             phase_c_high_drive,
   output logic             phase_c_low_drive,
   output logic             rotation_pulse_out
);
   // Pin synchronisers
   logic [27:0] pin_s1_r, pin_s2_r;
   logic        dir_q, dir_ovr_q, wrs_q, w120_q, pcs_q, oc_q;
   logic [7:0]  speed_q;
   logic [3:0]  lead_code;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_r <= 28'h0000000;
         pin_s2_r <= 28'h0000000;
      end else begin
         pin_s1_r <= {hall_c_plus, hall_c_minus, hall_b_plus, hall_b_minus, hall_a_plus,
                      hall_a_minus, direction_select, direction_overrange, width_reset_select,
                      width_overrange, pulse_count_select, overcurrent_sense,
                      speed_command_level, advance_angle_level};
         pin_s2_r <= pin_s1_r;
      end
   end

   assign {dir_q, dir_ovr_q, wrs_q, w120_q, pcs_q, oc_q} = pin_s2_r[21:16];
   assign speed_q   = pin_s2_r[15:8];
   assign lead_code = pin_s2_r[7:4];

   // Over-range on either pin wins; reset level ignored in 120 degree mode
   logic in_reset, w150;
   assign in_reset = dir_ovr_q | (wrs_q & ~w120_q);
   assign w150     = ~w120_q;

   // Hall filters
   logic [2:0] hall_raw, hall_f;
   // Legs are combined only after both have passed the synchroniser
   assign hall_raw = {pin_s2_r[27] & ~pin_s2_r[26], pin_s2_r[25] & ~pin_s2_r[24],
                      pin_s2_r[23] & ~pin_s2_r[22]};

   for (genvar i = 0; i < 3; i++) begin : g_hall
      bcc_deglitch bcc_deglitch_inst (
         .aclk    (aclk),
         .aresetn (aresetn),
         .raw     (hall_raw[i]),
         .filt    (hall_f[i])
      );
   end

   // Hall decode
   logic [2:0] hall_step;
   logic       hall_valid;
   always_comb begin
      hall_valid = 1'b1;
      case (hall_f)
         3'h1:    hall_step = 3'h0;
         3'h3:    hall_step = 3'h1;
         3'h2:    hall_step = 3'h2;
         3'h6:    hall_step = 3'h3;
         3'h4:    hall_step = 3'h4;
         3'h5:    hall_step = 3'h5;
         default: begin
            hall_step  = 3'h0;
            hall_valid = 1'b0;
         end
      endcase
   end

   // Sector timing and lead advance; free running through reset
   logic [2:0]  hall_prev_r, hall_prev_nxt;
   logic [19:0] elapsed_r, elapsed_nxt, period_r, period_nxt, thresh;
   logic        lead_done_r, lead_done_nxt, hall_edge;
   logic [23:0] lead_prod;

   assign hall_edge = hall_valid && (hall_f != hall_prev_r);
   assign lead_prod = 24'(period_r) * 24'(lead_code);
   localparam int LEAD_SHIFT_TOP = bcc_pkg::LEAD_SHIFT;
   assign thresh    = period_r - {1'b0, lead_prod[23:LEAD_SHIFT_TOP]};

   always_comb begin
      hall_prev_nxt = hall_valid ? hall_f : hall_prev_r;
      period_nxt    = hall_edge ? elapsed_r : period_r;
      elapsed_nxt   = elapsed_r;
      if (hall_edge) begin
         elapsed_nxt = 20'h00000;
      end else if (elapsed_r != bcc_pkg::PERIOD_MAX) begin
         elapsed_nxt = elapsed_r + 20'h00001;
      end
      lead_done_nxt = lead_done_r;
      if (hall_edge) begin
         lead_done_nxt = 1'b0;
      end else if (lead_code != 4'h0 && period_r != 20'h00000 && elapsed_r >= thresh) begin
         lead_done_nxt = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hall_prev_r <= 3'h0;
         elapsed_r   <= 20'h00000;
         period_r    <= 20'h00000;
         lead_done_r <= 1'b0;
      end else begin
         hall_prev_r <= hall_prev_nxt;
         elapsed_r   <= elapsed_nxt;
         period_r    <= period_nxt;
         lead_done_r <= lead_done_nxt;
      end
   end

   // Commutation step and phase choice
   logic [2:0] use_step, next_step, hi_tab, lo_tab;
   always_comb begin
      if (dir_q) begin
         next_step = (hall_step == 3'h0) ? 3'h5 : hall_step - 3'h1;
      end else begin
         next_step = (hall_step == 3'h5) ? 3'h0 : hall_step + 3'h1;
      end
      use_step = lead_done_r ? next_step : hall_step;
      case (use_step)
         3'h0:    {hi_tab, lo_tab} = {3'h1, 3'h2};
         3'h1:    {hi_tab, lo_tab} = {3'h1, 3'h4};
         3'h2:    {hi_tab, lo_tab} = {3'h2, 3'h4};
         3'h3:    {hi_tab, lo_tab} = {3'h2, 3'h1};
         3'h4:    {hi_tab, lo_tab} = {3'h4, 3'h1};
         3'h5:    {hi_tab, lo_tab} = {3'h4, 3'h2};
         default: {hi_tab, lo_tab} = {3'h0, 3'h0};
      endcase
   end

   // Overlap tail for 150 degree drive: outgoing phase held 15 degrees
   logic [2:0]  step_r, step_nxt, hi_sel_r, hi_sel_nxt, lo_sel_r, lo_sel_nxt;
   logic [2:0]  prev_hi_r, prev_hi_nxt, prev_lo_r, prev_lo_nxt, hi_want, lo_want;
   logic [19:0] ovl_r, ovl_nxt;

   always_comb begin
      step_nxt    = use_step;
      prev_hi_nxt = prev_hi_r;
      prev_lo_nxt = prev_lo_r;
      ovl_nxt     = (ovl_r != 20'h00000) ? ovl_r - 20'h00001 : ovl_r;
      if (!hall_valid) begin
         hi_sel_nxt = 3'h0;
         lo_sel_nxt = 3'h0;
      end else if (dir_q) begin
         hi_sel_nxt = lo_tab;
         lo_sel_nxt = hi_tab;
      end else begin
         hi_sel_nxt = hi_tab;
         lo_sel_nxt = lo_tab;
      end
      if (use_step != step_r) begin
         prev_hi_nxt = hi_sel_r;
         prev_lo_nxt = lo_sel_r;
         ovl_nxt     = period_r >> bcc_pkg::OVERLAP_SHIFT;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         step_r    <= 3'h0;
         hi_sel_r  <= 3'h0;
         lo_sel_r  <= 3'h0;
         prev_hi_r <= 3'h0;
         prev_lo_r <= 3'h0;
         ovl_r     <= 20'h00000;
      end else begin
         step_r    <= step_nxt;
         hi_sel_r  <= hi_sel_nxt;
         lo_sel_r  <= lo_sel_nxt;
         prev_hi_r <= prev_hi_nxt;
         prev_lo_r <= prev_lo_nxt;
         ovl_r     <= ovl_nxt;
      end
   end

   // Low wins on a shared phase, so a bad Hall jump cannot short a leg
   always_comb begin
      lo_want = lo_sel_r;
      hi_want = hi_sel_r;
      if (w150 && ovl_r != 20'h00000) begin
         lo_want = lo_sel_r | prev_lo_r;
         hi_want = hi_sel_r | prev_hi_r;
      end
      hi_want = hi_want & ~lo_want;
   end

   // Triangle carrier; rate set by the config prescaler
   logic [7:0]         config_r, config_nxt, pre_r, pre_nxt, carrier_r, carrier_nxt;
   bcc_pkg::bcc_ramp_t ramp_r, ramp_nxt;
   logic               valley;

   always_comb begin
      pre_nxt     = pre_r + 8'h01;
      carrier_nxt = carrier_r;
      ramp_nxt    = ramp_r;
      valley      = 1'b0;
      if (pre_r >= config_r) begin
         pre_nxt = 8'h00;
         case (ramp_r)
            bcc_pkg::BCC_UP: begin
               if (carrier_r == 8'hFF) begin
                  ramp_nxt    = bcc_pkg::BCC_DOWN;
                  carrier_nxt = 8'hFE;
               end else begin
                  carrier_nxt = carrier_r + 8'h01;
               end
            end
            bcc_pkg::BCC_DOWN: begin
               if (carrier_r == 8'h00) begin
                  ramp_nxt    = bcc_pkg::BCC_UP;
                  carrier_nxt = 8'h01;
                  valley      = 1'b1;
               end else begin
                  carrier_nxt = carrier_r - 8'h01;
               end
            end
            default: ramp_nxt = bcc_pkg::BCC_UP;
         endcase
      end
   end

   // PWM with on-time stretcher and overcurrent block
   logic       pwm_on_r, pwm_on_nxt, oc_block_r, oc_block_nxt;
   logic [6:0] on_cnt_r, on_cnt_nxt;

   always_comb begin
      pwm_on_nxt = (speed_q > carrier_r)
                   || (pwm_on_r && on_cnt_r < bcc_pkg::MIN_ON_LAST);
      on_cnt_nxt = 7'h00;
      if (pwm_on_r) begin
         on_cnt_nxt = (on_cnt_r == 7'h7F) ? on_cnt_r : on_cnt_r + 7'h01;
      end
      oc_block_nxt = oc_q | (oc_block_r & ~valley);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_r      <= 8'h00;
         carrier_r  <= 8'h00;
         ramp_r     <= bcc_pkg::BCC_UP;
         pwm_on_r   <= 1'b0;
         on_cnt_r   <= 7'h00;
         oc_block_r <= 1'b0;
      end else begin
         pre_r      <= pre_nxt;
         carrier_r  <= carrier_nxt;
         ramp_r     <= ramp_nxt;
         pwm_on_r   <= pwm_on_nxt;
         on_cnt_r   <= on_cnt_nxt;
         oc_block_r <= oc_block_nxt;
      end
   end

   // Drive and speed pulse outputs
   logic [2:0] hi_r, hi_nxt, lo_r, lo_nxt;
   logic       fg_r, fg_nxt;

   always_comb begin
      hi_nxt = hi_want & {3{pwm_on_r}};
      lo_nxt = lo_want & ~{3{oc_block_r}};
      if (in_reset) begin
         hi_nxt = 3'h0;
         lo_nxt = 3'h0;
      end
      fg_nxt = pcs_q ? hall_f[0] : ^hall_f;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hi_r <= 3'h0;
         lo_r <= 3'h0;
         fg_r <= 1'b0;
      end else begin
         hi_r <= hi_nxt;
         lo_r <= lo_nxt;
         fg_r <= fg_nxt;
      end
   end

   assign {phase_c_high_drive, phase_b_high_drive, phase_a_high_drive} = hi_r;
   assign {phase_c_low_drive, phase_b_low_drive, phase_a_low_drive}    = lo_r;
   assign rotation_pulse_out = fg_r;

   // AXI4-Lite: address and data taken in either order
   logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, bvalid_r, bvalid_nxt;
   logic        rvalid_r, rvalid_nxt, aw_have, w_have;
   logic [3:0]  aw_addr_r, aw_addr_nxt, wa;
   logic [31:0] w_data_r, w_data_nxt, rdata_r, rdata_nxt, wd, status;
   logic [3:0]  w_strb_r, w_strb_nxt, ws;
   logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;

   assign awready = ~aw_got_r & ~bvalid_r;
   assign wready  = ~w_got_r & ~bvalid_r;
   assign arready = ~rvalid_r;
   assign aw_have = aw_got_r | (awvalid & awready);
   assign w_have  = w_got_r | (wvalid & wready);
   assign wa      = aw_got_r ? aw_addr_r : awaddr;
   assign wd      = w_got_r ? w_data_r : wdata;
   assign ws      = w_got_r ? w_strb_r : wstrb;

   always_comb begin
      status = 32'h00000000;
      status[bcc_pkg::ST_STEP_LSB +: 3] = step_r;
      status[bcc_pkg::ST_HALL_LSB +: 3] = hall_f;
      status[bcc_pkg::ST_RESET]         = in_reset;
      status[bcc_pkg::ST_OC]            = oc_block_r;
      status[bcc_pkg::ST_W120]          = w120_q;
      status[bcc_pkg::ST_DIR]           = dir_q;
      status[bcc_pkg::ST_VALID]         = hall_valid;
   end

   always_comb begin
      aw_got_nxt  = aw_got_r | (awvalid & awready);
      aw_addr_nxt = (awvalid & awready) ? awaddr : aw_addr_r;
      w_got_nxt   = w_got_r | (wvalid & wready);
      w_data_nxt  = (wvalid & wready) ? wdata : w_data_r;
      w_strb_nxt  = (wvalid & wready) ? wstrb : w_strb_r;
      bvalid_nxt  = bvalid_r & ~bready;
      bresp_nxt   = bresp_r;
      config_nxt  = config_r;
      if (aw_have && w_have) begin
         aw_got_nxt = 1'b0;
         w_got_nxt  = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt  = bcc_pkg::RESP_OKAY;
         if (wa == bcc_pkg::ADDR_CONFIG) begin
            if (ws[0]) begin
               config_nxt = wd[7:0];
            end
         end else if (wa != bcc_pkg::ADDR_STATUS && wa != bcc_pkg::ADDR_PERIOD) begin
            bresp_nxt = bcc_pkg::RESP_SLVERR;
         end
      end
      rvalid_nxt = rvalid_r & ~rready;
      rdata_nxt  = rdata_r;
      rresp_nxt  = rresp_r;
      if (arvalid && arready) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = bcc_pkg::RESP_OKAY;
         case (araddr)
            bcc_pkg::ADDR_CONFIG: rdata_nxt = {24'h000000, config_r};
            bcc_pkg::ADDR_STATUS: rdata_nxt = status;
            bcc_pkg::ADDR_PERIOD: rdata_nxt = {12'h000, period_r};
            default: begin
               rdata_nxt = 32'h00000000;
               rresp_nxt = bcc_pkg::RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r  <= 1'b0;
         aw_addr_r <= 4'h0;
         w_got_r   <= 1'b0;
         w_data_r  <= 32'h00000000;
         w_strb_r  <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= 2'h0;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h00000000;
         rresp_r   <= 2'h0;
         config_r  <= bcc_pkg::CONFIG_RST;
      end else begin
         aw_got_r  <= aw_got_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_got_r   <= w_got_nxt;
         w_data_r  <= w_data_nxt;
         w_strb_r  <= w_strb_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         rvalid_r  <= rvalid_nxt;
         rdata_r   <= rdata_nxt;
         rresp_r   <= rresp_nxt;
         config_r  <= config_nxt;
      end
   end

   assign bvalid = bvalid_r;
   assign bresp  = bresp_r;
   assign rvalid = rvalid_r;
   assign rdata  = rdata_r;
   assign rresp  = rresp_r;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_oc_trip;
      oc_q ##1 oc_block_r;
   endsequence

   a_reset_all_off: assert property (in_reset |=> (hi_r == 3'h0 && lo_r == 3'h0))
      else $error("Drive active during reset");
   a_dir_test_reset: assert property (dir_ovr_q |=> (hi_r | lo_r) == 3'h0)
      else $error("Direction over-range did not reset");
   a_count_runs: assert property (in_reset && !hall_edge && elapsed_r != bcc_pkg::PERIOD_MAX
      |=> elapsed_r == $past(elapsed_r) + 20'h00001)
      else $error("Counter stalled in reset");
   a_no_shoot: assert property ((hi_r & lo_r) == 3'h0)
      else $error("Both sides of a phase on");
   a_min_on: assert property ($fell(pwm_on_r) |-> $past(on_cnt_r) >= bcc_pkg::MIN_ON_LAST)
      else $error("PWM on-pulse too short");
   a_oc_lows_off: assert property (s_oc_trip |=> lo_r == 3'h0)
      else $error("Low side on during overcurrent");
   a_oc_release: assert property (oc_block_r && !oc_q && valley |=> !oc_block_r)
      else $error("Overcurrent block not released at carrier valley");
   a_w120_single: assert property (w120_q |=> $countones(lo_r) <= 1)
      else $error("Overlap in 120 degree mode");
   a_fg_select: assert property (pcs_q |=> fg_r == $past(hall_f[0]))
      else $error("Speed pulse not one per revolution");
   a_pwm_high_only: assert property (hi_r != 3'h0 |-> $past(pwm_on_r))
      else $error("High side on outside PWM pulse");
endmodule : bcc_core

// file: shared/bcc_pkg.sv
package bcc_pkg;
   // Clock and time base
   localparam int CLK_MHZ   = 100;
   localparam int FILT_NS   = 1600;
   localparam int FILT_CYC  = (FILT_NS * CLK_MHZ + 999) / 1000;
   localparam int MIN_ON_NS = 600;
   localparam int MIN_ON_CYC = (MIN_ON_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] FILT_LAST   = 8'(FILT_CYC - 1);
   localparam logic [6:0] MIN_ON_LAST = 7'(MIN_ON_CYC - 1);

   // Sector timing
   localparam logic [19:0] PERIOD_MAX = 20'hFFFFF;
   localparam int LEAD_SHIFT    = 5;
   localparam int OVERLAP_SHIFT = 2;

   // Register map
   localparam logic [3:0] ADDR_CONFIG = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_PERIOD = 4'h8;
   localparam logic [7:0] CONFIG_RST  = 8'h00;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Status fields
   localparam int ST_STEP_LSB = 0;
   localparam int ST_HALL_LSB = 4;
   localparam int ST_RESET    = 8;
   localparam int ST_OC       = 9;
   localparam int ST_W120     = 10;
   localparam int ST_DIR      = 11;
   localparam int ST_VALID    = 12;

   // Carrier ramp direction
   typedef enum logic [0:0] {
      BCC_UP   = 1'b0,
      BCC_DOWN = 1'b1
   } bcc_ramp_t;
endpackage : bcc_pkg

// file: hw/bcc_deglitch.sv
`timescale 1ns/1ps
module bcc_deglitch (
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Pin level in, filtered level out
   input  wire logic raw,
   output logic      filt
);
   logic       s1_r, s2_r, filt_r, filt_nxt;
   logic [7:0] cnt_r, cnt_nxt;

   always_comb begin
      filt_nxt = filt_r;
      cnt_nxt  = 8'h00;
      if (s2_r != filt_r) begin
         if (cnt_r == bcc_pkg::FILT_LAST) begin
            filt_nxt = s2_r;
         end else begin
            cnt_nxt = cnt_r + 8'h01;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_r   <= 1'b0;
         s2_r   <= 1'b0;
         cnt_r  <= 8'h00;
         filt_r <= 1'b0;
      end else begin
         s1_r   <= raw;
         s2_r   <= s1_r;
         cnt_r  <= cnt_nxt;
         filt_r <= filt_nxt;
      end
   end

   assign filt = filt_r;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_filter_hold: assert property ($changed(filt_r) |-> $past(cnt_r) == bcc_pkg::FILT_LAST)
      else $error("Hall level passed before the filter time");
endmodule : bcc_deglitch

// file: sim/bcc_motor_model.sv
`timescale 1ns/1ps
module bcc_motor_model (
   // Rotor position from the bench
   input  wire logic [2:0] sector,
   // Differential Hall pins
   output logic            hall_a_plus,
   output logic            hall_a_minus,
   output logic            hall_b_plus,
   output logic            hall_b_minus,
   output logic            hall_c_plus,
   output logic            hall_c_minus
);
   logic [2:0] code;
   // Sensors drive both legs, so the minus leg is always the complement
   always_comb begin
      case (sector)
         3'h0:    code = 3'h1;
         3'h1:    code = 3'h3;
         3'h2:    code = 3'h2;
         3'h3:    code = 3'h6;
         3'h4:    code = 3'h4;
         3'h5:    code = 3'h5;
         default: code = 3'h0;
      endcase
   end
   assign {hall_c_plus, hall_b_plus, hall_a_plus}    = code;
   assign {hall_c_minus, hall_b_minus, hall_a_minus} = ~code;
endmodule : bcc_motor_model

// file: sim/tb_bldc_commutation_controller.sv
`timescale 1ns/1ps
module tb_bldc_commutation_controller;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, rotation_pulse_out;
   logic [3:0]  awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata, rd;
   logic [1:0]  bresp, rresp, resp;
   logic        hall_a_plus, hall_a_minus, hall_b_plus, hall_b_minus, hall_c_plus, hall_c_minus;
   logic        direction_select, direction_overrange, width_reset_select, width_overrange;
   logic        pulse_count_select, overcurrent_sense, fg_q, mon_on;
   logic [7:0]  speed_command_level, advance_angle_level;
   logic        phase_a_high_drive, phase_a_low_drive, phase_b_high_drive, phase_b_low_drive;
   logic        phase_c_high_drive, phase_c_low_drive;
   logic [2:0]  sector, hs, ls;
   int          n_fail, total_checks, n_edges, n_pulses, on_len, n_ovl;
   int          hi_ph [6] = '{0, 0, 1, 1, 2, 2};
   int          lo_ph [6] = '{1, 2, 2, 0, 0, 1};
   wire [2:0]   highs = {phase_c_high_drive, phase_b_high_drive, phase_a_high_drive};
   wire [2:0]   lows = {phase_c_low_drive, phase_b_low_drive, phase_a_low_drive};

   initial aclk = 1'b0;
   always #5 aclk = ~aclk;

   bcc_motor_model bcc_motor_model_inst (
      .sector, .hall_a_plus, .hall_a_minus, .hall_b_plus, .hall_b_minus, .hall_c_plus,
      .hall_c_minus
   );
   bcc_core bcc_core_inst (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .hall_a_plus, .hall_a_minus, .hall_b_plus, .hall_b_minus, .hall_c_plus, .hall_c_minus,
      .direction_select, .direction_overrange, .width_reset_select, .width_overrange,
      .pulse_count_select, .overcurrent_sense, .speed_command_level, .advance_angle_level,
      .phase_a_high_drive, .phase_a_low_drive, .phase_b_high_drive, .phase_b_low_drive,
      .phase_c_high_drive, .phase_c_low_drive, .rotation_pulse_out
   );

   // Drive watchers; a pulse cut by commutation is only judged while mon_on is set
   always @(posedge aclk) begin
      fg_q <= rotation_pulse_out;
      if (rotation_pulse_out && !fg_q) n_edges++;
      if ($countones(lows) > 1) n_ovl++;
      hs = hs | highs;
      ls = ls | lows;
      if (highs != 3'h0) on_len++;
      else begin
         if (on_len > 0) n_pulses++;
         if (mon_on && on_len > 0 && on_len < bcc_pkg::MIN_ON_CYC) chk(0, 1, "short on");
         on_len = 0;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask : chk

   task automatic conclude;
      if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : conclude

   task automatic hang;
      n_fail++;
      conclude();
   endtask : hang

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask : tick

   // Off the edge so the watchers never race the clearing
   task automatic clr;
      #1;
      {hs, ls} = 6'h00;
      {n_edges, n_pulses, n_ovl} = '0;
   endtask : clr

   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      do begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         resp = bresp;
      end while (!bvalid && n < 100);
      bready <= 1'b0;
      if (n >= 100) hang();
   endtask : axi_wr

   task automatic axi_rd(input logic [3:0] a);
      int n;
      n = 0;
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
         rd = rdata;
         resp = rresp;
      end while (!rvalid && n < 100);
      rready <= 1'b0;
      if (n >= 100) hang();
   endtask : axi_rd

   // Window spans a full carrier period so a chopped high side shows at least once
   task automatic see_drive(input int s, input logic rev);
      clr();
      tick(600);
      chk(32'(hs), 32'h1 << (rev ? lo_ph[s] : hi_ph[s]), "high side");
      chk(32'(ls), 32'h1 << (rev ? hi_ph[s] : lo_ph[s]), "low side");
   endtask : see_drive

   task automatic t_regs;
      axi_rd(bcc_pkg::ADDR_CONFIG);
      chk(rd, 32'(bcc_pkg::CONFIG_RST), "config reset");
      axi_wr(bcc_pkg::ADDR_CONFIG, 32'h00000003);
      axi_rd(bcc_pkg::ADDR_CONFIG);
      chk(rd, 32'h00000003, "config readback");
      axi_wr(bcc_pkg::ADDR_STATUS, 32'hFFFFFFFF);
      chk(32'(resp), 32'(bcc_pkg::RESP_OKAY), "status write");
      axi_rd(4'hC);
      chk({rd[29:0], resp}, 32'(bcc_pkg::RESP_SLVERR), "unmapped read");
      axi_wr(bcc_pkg::ADDR_CONFIG, 32'h00000000);
   endtask : t_regs

   task automatic t_commutate;
      for (int s = 0; s < 6; s++) begin
         sector <= 3'(s);
         direction_select <= 1'b0;
         tick(200);
         see_drive(s, 1'b0);
         direction_select <= 1'b1;
         tick(10);
         see_drive(s, 1'b1);
      end
   endtask : t_commutate

   task automatic t_glitch;
      sector <= 3'h0;
      direction_select <= 1'b0;
      tick(200);
      sector <= 3'h1;
      clr();
      tick(150);
      sector <= 3'h0;
      tick(200);
      chk(32'(ls), 32'h1 << lo_ph[0], "glitch passed");
   endtask : t_glitch

   task automatic t_reset;
      {width_reset_select, width_overrange} <= 2'h2;
      tick(5);
      clr();
      tick(1);
      sector <= 3'h2;
      tick(300);
      chk(32'({hs, ls}), 32'h0, "drive in reset");
      axi_rd(bcc_pkg::ADDR_STATUS);
      chk(32'(rd[bcc_pkg::ST_RESET]), 32'h1, "reset status");
      width_overrange <= 1'b1;
      tick(5);
      see_drive(2, 1'b0);
      width_reset_select <= 1'b0;
      direction_overrange <= 1'b1;
      tick(5);
      clr();
      tick(300);
      chk(32'({hs, ls}), 32'h0, "drive on test level");
      direction_overrange <= 1'b0;
      tick(10);
   endtask : t_reset

   task automatic t_overcurrent;
      overcurrent_sense <= 1'b1;
      tick(5);
      clr();
      tick(600);
      chk(32'(ls), 32'h0, "lows under overcurrent");
      chk(32'(hs), 32'h1 << hi_ph[2], "high under overcurrent");
      overcurrent_sense <= 1'b0;
      tick(520);
      see_drive(2, 1'b0);
   endtask : t_overcurrent

   task automatic t_spin(input logic one, input int exp);
      pulse_count_select <= one;
      sector <= 3'h0;
      tick(300);
      clr();
      for (int i = 1; i <= 12; i++) begin
         tick(300);
         sector <= 3'(i % 6);
      end
      tick(300);
      chk(32'(n_edges), 32'(exp), "speed pulse count");
   endtask : t_spin

   task automatic t_spins;
      t_spin(1'b1, 2);
      chk(32'(n_ovl), 32'h0, "overlap at 120");
      width_overrange <= 1'b0;
      advance_angle_level <= 8'hF0;
      t_spin(1'b0, 6);
      chk(32'(n_ovl > 0), 32'h1, "no overlap at 150");
      tick(300);
      chk(32'(lows), 32'h1 << lo_ph[1], "lead advance");
      {width_overrange, advance_angle_level} <= 9'h100;
   endtask : t_spins

   task automatic t_min_on;
      sector <= 3'h3;
      speed_command_level <= 8'h01;
      tick(300);
      clr();
      mon_on = 1'b1;
      tick(2000);
      mon_on = 1'b0;
      chk(32'(n_pulses > 0), 32'h1, "narrow duty pulses");
      chk(32'(hs), 32'h1 << hi_ph[3], "chopped side");
      speed_command_level <= 8'h00;
      tick(300);
      clr();
      tick(1100);
      chk(32'(n_pulses), 32'h0, "zero command pulses");
      sector <= 3'h6;
      tick(300);
      clr();
      tick(600);
      chk(32'({hs, ls}), 32'h0, "invalid hall drive");
   endtask : t_min_on

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, wstrb} = {40'h0, 4'hF};
      {direction_select, direction_overrange, width_reset_select, overcurrent_sense} = '0;
      {width_overrange, pulse_count_select} = 2'h3;
      {speed_command_level, advance_angle_level} = 16'h8000;
      {sector, hs, ls, fg_q, mon_on} = '0;
      tick(5);
      aresetn <= 1'b1;
      tick(1);
      t_regs();
      t_commutate();
      t_glitch();
      t_reset();
      t_overcurrent();
      t_spins();
      t_min_on();
      conclude();
   end
endmodule : tb_bldc_commutation_controller
